// File: src/epi_pkg.sv
package epi_pkg;

  // Register byte offsets.
  localparam logic [5:0] EPI_OFF_TRIG   = 6'h00;
  localparam logic [5:0] EPI_OFF_DIR    = 6'h04;
  localparam logic [5:0] EPI_OFF_DOUT   = 6'h08;
  localparam logic [5:0] EPI_OFF_PIN    = 6'h0C;
  localparam logic [5:0] EPI_OFF_FLAG   = 6'h10;
  localparam logic [5:0] EPI_OFF_FUNC   = 6'h14;
  localparam logic [5:0] EPI_OFF_SRCPRI = 6'h18;
  localparam logic [5:0] EPI_OFF_MASK   = 6'h1C;
  localparam logic [5:0] EPI_OFF_SRCEN  = 6'h20;
  localparam logic [5:0] EPI_OFF_CUR    = 6'h24;
  localparam logic [5:0] EPI_OFF_ACK    = 6'h28;

  // Pin positions and their fixed levels.
  localparam int EPI_NPIN = 3;
  localparam int EPI_PIN_L7 = 2;
  localparam int EPI_PIN_L4 = 1;
  localparam int EPI_PIN_L1 = 0;
  localparam logic [2:0] EPI_LVL_PIN_L7 = 3'h7;
  localparam logic [2:0] EPI_LVL_PIN_L4 = 3'h4;
  localparam logic [2:0] EPI_LVL_PIN_L1 = 3'h1;
  localparam logic [2:0] EPI_LVL_NMI    = 3'h7;

  // Vector numbering: base plus source index.
  localparam logic [7:0] EPI_VEC_BASE = 8'h40;

  // Reset values.
  localparam logic [5:0] EPI_RST_TRIG = 6'h00;
  localparam logic [2:0] EPI_RST_FUNC = 3'h7;
  localparam logic [2:0] EPI_RST_MASK = 3'h0;

  typedef enum logic [1:0] {
    EPI_TRIG_LEVEL = 2'h0,
    EPI_TRIG_RISE  = 2'h1,
    EPI_TRIG_FALL  = 2'h2,
    EPI_TRIG_BOTH  = 2'h3
  } epi_trig_t;

endpackage

// File: src/epi_prio.sv
`timescale 1ns/1ps
module epi_prio
  import epi_pkg::*;
#(
  parameter int N = 8
)(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Source side.
  epi_src_if.ctl   src
);

  logic [2:0] next_lvl;
  logic [7:0] next_vec;

  // Highest active level wins; within a level the lowest index wins.
  always_comb
  begin
    next_lvl = 3'h0;
    next_vec = 8'h00;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (src.req[i] && src.en[i] &&
          (src.lvl[i*3 +: 3] > src.mask ||
           src.lvl[i*3 +: 3] == EPI_LVL_NMI) &&
          src.lvl[i*3 +: 3] >= next_lvl)
      begin
        next_lvl = src.lvl[i*3 +: 3];
        next_vec = EPI_VEC_BASE + 8'(i);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      src.pend_lvl <= 3'h0;
      src.pend_vec <= 8'h00;
    end
    else
    begin
      src.pend_lvl <= next_lvl;
      src.pend_vec <= next_vec;
    end
  end

endmodule

// File: src/epi_src_if.sv
`timescale 1ns/1ps
interface epi_src_if #(parameter int N = 8);
  logic [N-1:0] req;
  logic [N-1:0] en;
  logic [N*3-1:0] lvl;
  logic [2:0] mask;
  logic [2:0] pend_lvl;
  logic [7:0] pend_vec;
  modport ctl (input req, en, lvl, mask, output pend_lvl, pend_vec);
  modport top (output req, en, lvl, mask, input pend_lvl, pend_vec);
endinterface

// File: src/epi_top.sv
`timescale 1ns/1ps
module epi_top
  import epi_pkg::*;
#(
  parameter int NPER = 5
)(
  // Clock and reset.
  input  wire logic            clk,
  input  wire logic            rst_n,
  // Register port.
  input  wire logic [5:0]      addr,
  input  wire logic [31:0]     wdata,
  input  wire logic            wr,
  input  wire logic            rd,
  output logic      [31:0]     rdata,
  // External pins, active low as interrupts.
  input  wire logic [2:0]      pin_in,
  output logic      [2:0]      pin_out,
  output logic      [2:0]      pin_oe,
  output logic                 dma_request_ch0,
  // On-chip peripheral requests, held until cleared at their source.
  input  wire logic [NPER-1:0] per_req,
  // Core side.
  output logic      [2:0]      core_level,
  output logic      [7:0]      core_vector,
  input  wire logic            core_ack,
  output logic                 vector_fetch_cycle
);

  localparam int NSRC = EPI_NPIN + NPER;

  ////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [5:0]        trig;
  logic [2:0]        dir;
  logic [2:0]        dout;
  logic [2:0]        func;
  logic [2:0]        flag;
  logic [2:0]        imask;
  logic [NSRC-1:0]   src_en;
  logic [NPER*3-1:0] per_lvl;
  logic [2:0]        pin_s1;
  logic [2:0]        pin_s2;
  logic [2:0]        pin_d;
  logic [2:0]        edge_hit;
  logic [2:0]        pin_req;
  logic [10:0]       cur_ack;
  logic [2:0]        flag_clr;
  logic [31:0]       rd_view;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
    hit = (a == o);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; the first stage is read only by the second.

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1 <= 3'h7;
      pin_s2 <= 3'h7;
    end
    else
    begin
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
    end
  end

  // The edge stage resets to the idle level, so no false edge follows reset.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pin_d <= 3'h7;
    else
      pin_d <= pin_s2;
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-pin trigger detection.

  genvar g;
  generate
    for (g = 0; g < EPI_NPIN; g++)
    begin : g_pin
      epi_trig_t mode;
      logic      rise;
      logic      fall;
      assign mode = epi_trig_t'(trig[g*2 +: 2]);
      assign rise = pin_s2[g] && !pin_d[g];
      assign fall = !pin_s2[g] && pin_d[g];
      always_comb
      begin
        case (mode)
          EPI_TRIG_RISE: edge_hit[g] = rise;
          EPI_TRIG_FALL: edge_hit[g] = fall;
          EPI_TRIG_BOTH: edge_hit[g] = rise || fall;
          default:       edge_hit[g] = 1'b0;
        endcase
      end
      // Level mode follows the low pin; edge modes use the sticky flag.
      assign pin_req[g] = func[g] && !dir[g] &&
                          ((mode == EPI_TRIG_LEVEL) ? !pin_s2[g]
                                                    : flag[g]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Edge flags: a new edge wins over a same-cycle clear.

  // Ones written to the flag register clear those flags.
  assign flag_clr = (wr && hit(addr, EPI_OFF_FLAG)) ? wdata[2:0] : 3'h0;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flag <= 3'h0;
    else
      flag <= (flag & ~flag_clr) | (edge_hit & func);
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes, one process for each register.

  // Two trigger bits per pin select level, rise, fall or both.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      trig <= EPI_RST_TRIG;
    else if (wr && hit(addr, EPI_OFF_TRIG))
      trig <= wdata[5:0];
  end

  // A one in the direction register makes the pin an output when its function bit is zero.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      dir <= 3'h0;
    else if (wr && hit(addr, EPI_OFF_DIR))
      dir <= wdata[2:0];
  end

  // Drive values for pins used as outputs.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      dout <= 3'h0;
    else if (wr && hit(addr, EPI_OFF_DOUT))
      dout <= wdata[2:0];
  end

  // A one with direction zero keeps the pin an interrupt input; zero frees it for other use.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      func <= EPI_RST_FUNC;
    else if (wr && hit(addr, EPI_OFF_FUNC))
      func <= wdata[2:0];
  end

  // Levels at or below the mask are held off, except level seven.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      imask <= EPI_RST_MASK;
    else if (wr && hit(addr, EPI_OFF_MASK))
      imask <= wdata[2:0];
  end

  // Each source has its own enable, all off after reset.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      src_en <= '0;
    else if (wr && hit(addr, EPI_OFF_SRCEN))
      src_en <= wdata[NSRC-1:0];
  end

  // Three level bits for each on-chip source.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      per_lvl <= '0;
    else if (wr && hit(addr, EPI_OFF_SRCPRI))
      per_lvl <= wdata[NPER*3-1:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin function: interrupt input, GPIO, or DMA request on level four.

  always_comb
  begin
    pin_out = dout;
    pin_oe  = ~func & dir;
  end

  ////////////////////////////////////////////////////////////////////////
  // DMA request on the shared level-four pin.

  // The level-four pin feeds the DMA request only when not an interrupt.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      dma_request_ch0 <= 1'b0;
    else
      dma_request_ch0 <= !func[EPI_PIN_L4] && !dir[EPI_PIN_L4] &&
                         !pin_s2[EPI_PIN_L4];
  end

  ////////////////////////////////////////////////////////////////////////
  // Priority and vector generation; pins carry fixed levels.

  epi_src_if #(.N(NSRC)) src ();

  assign src.req  = {per_req, pin_req};
  assign src.en   = src_en;
  assign src.mask = imask;
  assign src.lvl  = {per_lvl, EPI_LVL_PIN_L7, EPI_LVL_PIN_L4,
                     EPI_LVL_PIN_L1};

  epi_prio #(.N(NSRC)) u_prio (
    .clk   (clk),
    .rst_n (rst_n),
    .src   (src)
  );

  ////////////////////////////////////////////////////////////////////////
  // Core outputs come straight from the priority stage's registers.

  assign core_level  = src.pend_lvl;
  assign core_vector = src.pend_vec;

  // Acknowledge is answered internally and never leaves the unit.
  assign vector_fetch_cycle = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Acknowledge capture: the level and vector the core last took.

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cur_ack <= '0;
    else if (core_ack)
      cur_ack <= {src.pend_lvl, src.pend_vec};
  end

  ////////////////////////////////////////////////////////////////////////
  // Register reads, one cycle later; unmapped reads return zero.

  always_comb
  begin
    case (addr)
      EPI_OFF_TRIG:   rd_view = 32'(trig);
      EPI_OFF_DIR:    rd_view = 32'(dir);
      EPI_OFF_DOUT:   rd_view = 32'(dout);
      EPI_OFF_PIN:    rd_view = 32'(pin_s2);
      EPI_OFF_FLAG:   rd_view = 32'(flag);
      EPI_OFF_FUNC:   rd_view = 32'(func);
      EPI_OFF_SRCPRI: rd_view = 32'(per_lvl);
      EPI_OFF_MASK:   rd_view = 32'(imask);
      EPI_OFF_SRCEN:  rd_view = 32'(src_en);
      EPI_OFF_CUR:    rd_view = 32'({src.pend_lvl, src.pend_vec});
      EPI_OFF_ACK:    rd_view = 32'(cur_ack);
      default:        rd_view = 32'h0000_0000;
    endcase
  end

  // The answer stands for exactly one cycle and reads zero otherwise.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 32'h0000_0000;
    else if (rd)
      rdata <= rd_view;
    else
      rdata <= 32'h0000_0000;
  end

endmodule

// File: test/epi_ext_dev.sv
`timescale 1ns/1ps
module epi_ext_dev #(
  parameter int NPER = 5
)(
  // Clock.
  input  wire logic            clk,
  // Pins.
  input  wire logic [2:0]      pin_out,
  input  wire logic [2:0]      pin_oe,
  output logic      [2:0]      pin_in,
  // Bench commands.
  input  wire logic [2:0]      pull_low,
  input  wire logic [NPER-1:0] raise,
  input  wire logic [NPER-1:0] clear,
  // Peripheral requests.
  output logic      [NPER-1:0] per_req
);
  // Pins have pull-ups; a device asks for service by pulling low.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ~pull_low);
  // A request stays up until the service routine clears it.
  initial per_req = '0;
  always @(posedge clk) per_req <= (per_req | raise) & ~clear;
endmodule

// File: test/epi_monitor.sv
`timescale 1ns/1ps
module epi_monitor
  import epi_pkg::*;
#(
  parameter int NPER = 5
)(
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst_n,
  // Watched ports.
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic [2:0]  pin_in,
  input wire logic [2:0]  pin_oe,
  input wire logic        dma_request_ch0,
  input wire logic [2:0]  core_level,
  input wire logic [7:0]  core_vector,
  input wire logic        vector_fetch_cycle
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_no_ack_cycle:
    assert property (!vector_fetch_cycle) else $error("ack cycle issued");
  chk_vec_in_table:
    assert property (core_level != 3'h0 |->
      core_vector - EPI_VEC_BASE < 8'(3 + NPER)) else $error("bad vector");
  chk_pin7_level:
    assert property (core_level != 3'h0 && core_vector == 8'h42 |->
      core_level == EPI_LVL_PIN_L7) else $error("pin 7 level wrong");
  chk_pin4_level:
    assert property (core_level != 3'h0 && core_vector == 8'h41 |->
      core_level == EPI_LVL_PIN_L4) else $error("pin 4 level wrong");
  chk_pin1_level:
    assert property (core_level != 3'h0 && core_vector == 8'h40 |->
      core_level == EPI_LVL_PIN_L1) else $error("pin 1 level wrong");
  chk_dma_follows_pin:
    assert property (dma_request_ch0 |-> !$past(pin_in[1], 3))
      else $error("dma request without low pin");
  chk_dma_input_only:
    assert property (dma_request_ch0 |-> !$past(pin_oe[1]))
      else $error("dma request while pin drives");
  chk_rdata_idle:
    assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data outside answer cycle");
endmodule

// File: test/epi_top_tb.sv
`timescale 1ns/1ps
module epi_top_tb;
  import epi_pkg::*;
  localparam int NPER = 5;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, core_ack = 0, rd_d = 0;
  logic [5:0] addr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [2:0] pin_in, pin_out, pin_oe, pull = '0, core_level;
  logic [NPER-1:0] per_req, raise = '0, clear = '0;
  logic dma_request_ch0, vector_fetch_cycle;
  logic [7:0] core_vector;
  logic [43:0] notes[$];
  int mismatches = 0, n_compared = 0, cyc = 0;
  epi_top #(.NPER(NPER)) uut (.*);
  epi_ext_dev #(.NPER(NPER)) dev (.pull_low(pull), .*);
  initial forever #10 clk = ~clk;
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    rd_d <= rd;
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      mismatches++;
      close_out;
    end
  end
  task automatic cmp_reg(input logic [31:0] e);
    n_compared++;
    if (rdata !== e)
    begin
      mismatches++;
      $display("mismatch rdata exp %h got %h", e, rdata);
    end
  endtask
  task automatic cmp_core(input logic [11:0] e);
    n_compared++;
    if ({dma_request_ch0, core_level, core_vector} !== e)
    begin
      mismatches++;
      $display("mismatch core exp %h got %h", e,
               {dma_request_ch0, core_level, core_vector});
    end
  endtask
  // The oldest note belongs to the read answered in this cycle.
  always @(negedge clk)
    if (rd_d)
    begin
      cmp_reg(notes[0][31:0]);
      cmp_core(notes[0][43:32]);
      void'(notes.pop_front());
    end
  task automatic put(input logic [5:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic get(input logic [5:0] a, input logic [31:0] e,
                     input logic [11:0] c);
    addr <= a;
    rd <= 1'b1;
    notes.push_back({c, e});
    @(posedge clk) rd <= 1'b0;
    @(posedge clk);
  endtask
  initial
  begin
    int j, k, lo;
    logic [2:0] l;
    logic g;
    void'($urandom(32'hB7CE));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    get(EPI_OFF_FUNC, 32'(EPI_RST_FUNC), '0);
    get(EPI_OFF_TRIG, '0, '0);
    get(6'h3C, '0, '0);
    $display("test reset done");
    put(EPI_OFF_SRCEN, 32'hFF);
    put(EPI_OFF_MASK, 32'h7);
    pull <= 3'h4;
    repeat (5) @(posedge clk);
    get(EPI_OFF_CUR, 32'h742, 12'h742);
    core_ack <= 1'b1;
    @(posedge clk) core_ack <= 1'b0;
    get(EPI_OFF_ACK, 32'h742, 12'h742);
    pull <= 3'h0;
    put(EPI_OFF_MASK, 32'h0);
    repeat (5) @(posedge clk);
    get(EPI_OFF_CUR, '0, '0);
    $display("test level seven done");
    for (int m = 0; m < 4; m++)
    begin
      put(EPI_OFF_TRIG, 32'(m));
      put(EPI_OFF_FLAG, 32'h7);
      pull <= 3'h1;
      repeat (5) @(posedge clk);
      get(EPI_OFF_FLAG, 32'(m[1]), (m != 1) ? 12'h140 : 12'h0);
      pull <= 3'h0;
      repeat (5) @(posedge clk);
      get(EPI_OFF_FLAG, 32'(m != 0), (m != 0) ? 12'h140 : 12'h0);
    end
    put(EPI_OFF_FLAG, 32'h7);
    get(EPI_OFF_CUR, '0, '0);
    $display("test trigger modes done");
    for (int i = 0; i < 4; i++)
    begin
      j = $urandom % NPER;
      k = (j + 1 + $urandom % (NPER - 1)) % NPER;
      l = 3'(1 + $urandom % 6);
      lo = (j < k) ? j : k;
      put(EPI_OFF_SRCPRI, {17'h0, {5{l}}});
      raise <= NPER'(1 << j) | NPER'(1 << k);
      @(posedge clk) raise <= '0;
      repeat (3) @(posedge clk);
      get(EPI_OFF_CUR, {l, 8'(67 + lo)}, {1'b0, l, 8'(67 + lo)});
      // The pending register needs one more edge to show the other source.
      clear <= NPER'(1 << lo);
      @(posedge clk) clear <= '0;
      @(posedge clk);
      get(EPI_OFF_CUR, {l, 8'(67 + j + k - lo)},
          {1'b0, l, 8'(67 + j + k - lo)});
      clear <= '1;
      @(posedge clk) clear <= '0;
    end
    $display("test peripherals done");
    g = 1'($urandom);
    put(EPI_OFF_FUNC, 32'h4);
    put(EPI_OFF_DIR, 32'h1);
    put(EPI_OFF_DOUT, {31'h0, g});
    pull <= 3'h2;
    repeat (5) @(posedge clk);
    get(EPI_OFF_PIN, {29'h0, 2'b10, g}, 12'h800);
    put(EPI_OFF_FUNC, 32'h7);
    put(EPI_OFF_DIR, 32'h0);
    repeat (5) @(posedge clk);
    get(EPI_OFF_PIN, 32'h5, 12'h441);
    $display("test pin functions done");
    close_out;
  end
endmodule
bind epi_top epi_monitor #(.NPER(NPER)) mon (.*);
